// ### pkg/jitter_attenuator_map.vh
// Purpose: register offsets, reset values and field positions of the jitter attenuator
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: printed offsets are register indices; byte address is four times the index
`ifndef JITTER_ATTENUATOR_MAP_VH
`define JITTER_ATTENUATOR_MAP_VH

`define JA_IDX_CTRL 8'h18
`define JA_IDX_IN_DIV 8'h19
`define JA_IDX_OUT_DIV 8'h1A
`define JA_IDX_STATUS 8'h1B
`define JA_IDX_TIMING 8'h1C

`define JA_CTRL_SYNC 0
`define JA_CTRL_SELF_CENTER_ENABLE 1
`define JA_CTRL_LIMIT 2
`define JA_CTRL_RESET 8'h01

`define JA_TIM_OCLK_LO 0
`define JA_TIM_OCLK_HI 1
`define JA_TIM_AUXSEL 2
`define JA_TIM_SMSEL 3
`define JA_TIM_RESET 8'h00

`define JA_DIV_RESET 8'h2F
`define JA_FIFO_DEPTH 48
`define JA_CENTER_MARGIN 4
`define JA_LIMIT_MARGIN 1
`define JA_NCO_WIDTH 24
`define JA_NCO_NOMINAL 24'h0C0000
`define JA_NCO_GAIN 6

`endif

// ### src/ja_fifo.v
// Purpose: single-clock bit FIFO between backplane side and smoothed output side
// Assumes: width and depth are parameters; read data registered
// Notes: valid and ready on both sides; count exported for centring and limits
`timescale 1ns/10ps
module ja_fifo #(
  parameter WIDTH = 1,
  parameter DEPTH = 48,
  parameter AW = 6
)(
  input wire pclk,
  input wire presetn,
  input wire [WIDTH-1:0] wr_data,
  input wire wr_valid,
  output wire wr_ready,
  output reg [WIDTH-1:0] rd_data,
  output wire rd_valid,
  input wire rd_ready,
  input wire skip,
  output reg [AW:0] level
);
  // ----------------------------------------
  // storage and pointers
  // ----------------------------------------
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wptr_reg;
  reg [AW-1:0] rptr_reg;
  wire do_wr;
  wire do_rd;
  wire do_skip;

  function [AW-1:0] bump;
    input [AW-1:0] p;
    begin
      if (p == DEPTH - 1)
        bump = {AW{1'b0}};
      else
        bump = p + 1'b1;
    end
  endfunction

  assign wr_ready = (level != DEPTH);
  assign rd_valid = (level != 0);
  assign do_wr = wr_valid && wr_ready;
  assign do_rd = rd_valid && rd_ready;
  assign do_skip = skip && !do_rd && (level > 1);

  always @(posedge pclk)
  begin
    if (do_wr)
      mem[wptr_reg] <= wr_data;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wptr_reg <= {AW{1'b0}};
      rptr_reg <= {AW{1'b0}};
      level <= {(AW+1){1'b0}};
      rd_data <= {WIDTH{1'b0}};
    end
    else
    begin
      if (do_wr)
        wptr_reg <= bump(wptr_reg);
      if (do_rd || do_skip)
      begin
        rptr_reg <= bump(rptr_reg);
        rd_data <= mem[rptr_reg];
      end
      level <= level + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, (do_rd || do_skip)};
    end
  end
endmodule

// ### src/jitter_attenuator.v
// Purpose: digital jitter attenuator with divided-clock phase comparison and bit FIFO
// Assumes: backplane and aux clocks arrive as pins sampled on pclk; pclk is 50 MHz
// Notes: smoothed clock is made by an NCO steered by the phase comparator
//
// Operation
// - after reset the block attenuates with the smoothed clock referenced to the backplane clock.
// - the phase synchronisation bit resets to one.
// - both clocks are divided by 48 by default before the phase comparator.
// - with synchronisation on, FIFO latency in bits equals the clock phase delay in UI.
// - with divide by 193 each comparator input runs at 8 kHz.
// - self-centring places the read pointer at least 4 UI from the FIFO end, then stops.
// - limit control nudges the read pointer away within one UI of over or underflow.
// - with sync off and centring plus limit on, phase differences up to 40 UI are tolerated.
// - input divisor sits at index 19h and output divisor at 1Ah, both writable.
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "jitter_attenuator_map.vh"
module jitter_attenuator #(
  parameter DEPTH = `JA_FIFO_DEPTH,
  parameter NCO_W = `JA_NCO_WIDTH
)(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire backplane_tx_clock,
  input wire backplane_tx_data,
  input wire aux_tx_clock_in,
  output reg smoothed_tx_clock_out,
  output reg tx_data_out,
  output wire data_in_ready
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  localparam ST_FILL = 3'b001;
  localparam ST_CENTER = 3'b010;
  localparam ST_RUN = 3'b100;

  reg [7:0] ctrl_reg;
  reg [7:0] input_divisor_reg;
  reg [7:0] output_divisor_reg;
  reg [7:0] timing_reg;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [2:0] bp_sync_reg;
  reg [2:0] aux_sync_reg;
  reg bp_data_s1_reg;
  reg bp_data_s2_reg;
  reg bp_data_s3_reg;
  reg [7:0] in_cnt_reg;
  reg [7:0] out_cnt_reg;
  reg in_tick_reg;
  reg out_tick_reg;
  reg signed [9:0] phase_reg;
  reg [NCO_W-1:0] nco_reg;
  reg [NCO_W-1:0] step_reg;
  reg [6:0] ui_delay_reg;
  reg centered_reg;
  reg nudge_reg;
  reg read_done_reg;

  wire sync_en;
  wire self_center_enable_en;
  wire limit_en;
  wire [1:0] output_clock_select;
  wire aux_clock_input_select;
  wire smooth_clock_out_select;
  wire bp_rise;
  wire aux_rise;
  wire in_edge;
  wire nco_rise;
  wire out_edge;
  wire [6:0] level;
  wire fifo_rd_valid;
  wire fifo_rd_data;
  wire near_over;
  wire near_under;
  wire read_now;
  wire skip;
  wire [9:0] reg_idx;
  wire apb_wr;
  wire mapped;
  wire [NCO_W+31:0] step_wide;

  assign sync_en = ctrl_reg[`JA_CTRL_SYNC];
  assign self_center_enable_en = ctrl_reg[`JA_CTRL_SELF_CENTER_ENABLE];
  assign limit_en = ctrl_reg[`JA_CTRL_LIMIT];
  assign output_clock_select = timing_reg[`JA_TIM_OCLK_HI:`JA_TIM_OCLK_LO];
  assign aux_clock_input_select = timing_reg[`JA_TIM_AUXSEL];
  assign smooth_clock_out_select = timing_reg[`JA_TIM_SMSEL];

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  assign reg_idx = paddr[11:2];
  assign pready = 1'b1;
  assign mapped = (reg_idx == {2'b00, `JA_IDX_CTRL}) || (reg_idx == {2'b00, `JA_IDX_IN_DIV}) ||
    (reg_idx == {2'b00, `JA_IDX_OUT_DIV}) || (reg_idx == {2'b00, `JA_IDX_STATUS}) ||
    (reg_idx == {2'b00, `JA_IDX_TIMING});
  assign pslverr = psel && penable && !mapped;
  assign apb_wr = psel && penable && pwrite;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= `JA_CTRL_RESET;
      input_divisor_reg <= `JA_DIV_RESET;
      output_divisor_reg <= `JA_DIV_RESET;
      timing_reg <= `JA_TIM_RESET;
    end
    else if (apb_wr)
    begin
      if (reg_idx == {2'b00, `JA_IDX_CTRL})
        ctrl_reg <= {5'h00, pwdata[2:0]};
      if (reg_idx == {2'b00, `JA_IDX_IN_DIV})
        input_divisor_reg <= pwdata[7:0];
      if (reg_idx == {2'b00, `JA_IDX_OUT_DIV})
        output_divisor_reg <= pwdata[7:0];
      if (reg_idx == {2'b00, `JA_IDX_TIMING})
        timing_reg <= {4'h0, pwdata[3:0]};
    end
  end

  always @*
  begin
    prdata = 32'h00000000;
    if (reg_idx == {2'b00, `JA_IDX_CTRL})
      prdata = {24'h000000, ctrl_reg};
    else if (reg_idx == {2'b00, `JA_IDX_IN_DIV})
      prdata = {24'h000000, input_divisor_reg};
    else if (reg_idx == {2'b00, `JA_IDX_OUT_DIV})
      prdata = {24'h000000, output_divisor_reg};
    else if (reg_idx == {2'b00, `JA_IDX_TIMING})
      prdata = {24'h000000, timing_reg};
    else if (reg_idx == {2'b00, `JA_IDX_STATUS})
      prdata = {14'h0000, phase_reg[7:0], level, near_over, near_under, state_reg[2]};
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bp_sync_reg <= 3'h0;
      aux_sync_reg <= 3'h0;
      bp_data_s1_reg <= 1'b0;
      bp_data_s2_reg <= 1'b0;
      bp_data_s3_reg <= 1'b0;
    end
    else
    begin
      bp_sync_reg <= {bp_sync_reg[1:0], backplane_tx_clock};
      aux_sync_reg <= {aux_sync_reg[1:0], aux_tx_clock_in};
      bp_data_s1_reg <= backplane_tx_data;
      bp_data_s2_reg <= bp_data_s1_reg;
      bp_data_s3_reg <= bp_data_s2_reg;
    end
  end

  assign bp_rise = bp_sync_reg[1] && !bp_sync_reg[2];
  assign aux_rise = aux_sync_reg[1] && !aux_sync_reg[2];
  // reference edge: backplane clock unless aux input selected
  assign in_edge = aux_clock_input_select ? aux_rise : bp_rise;

  // ----------------------------------------
  // divisors and phase comparator
  // ----------------------------------------
  function [7:0] div_step;
    input [7:0] cnt;
    input [7:0] limit;
    begin
      if (cnt >= limit)
        div_step = 8'h00;
      else
        div_step = cnt + 8'h01;
    end
  endfunction

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      in_cnt_reg <= 8'h00;
      out_cnt_reg <= 8'h00;
      in_tick_reg <= 1'b0;
      out_tick_reg <= 1'b0;
      phase_reg <= 10'sh000;
    end
    else
    begin
      // divide by divisor plus one: 47 gives 48, C0H gives 193
      in_tick_reg <= in_edge && (in_cnt_reg >= input_divisor_reg);
      out_tick_reg <= out_edge && (out_cnt_reg >= output_divisor_reg);
      if (in_edge)
        in_cnt_reg <= div_step(in_cnt_reg, input_divisor_reg);
      if (out_edge)
        out_cnt_reg <= div_step(out_cnt_reg, output_divisor_reg);
      if (in_tick_reg && !out_tick_reg && phase_reg != 10'sh1FF)
        phase_reg <= phase_reg + 10'sh001;
      else if (out_tick_reg && !in_tick_reg && phase_reg != 10'sh200)
        phase_reg <= phase_reg - 10'sh001;
    end
  end

  // ----------------------------------------
  // digital pll and smoothed clock
  // ----------------------------------------
  // wide sum, cut back to the accumulator width
  assign step_wide = {{32{1'b0}}, `JA_NCO_NOMINAL} +
    {{32{1'b0}}, {(NCO_W-10){phase_reg[9]}}, phase_reg} * `JA_NCO_GAIN;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nco_reg <= {NCO_W{1'b0}};
      step_reg <= `JA_NCO_NOMINAL;
      smoothed_tx_clock_out <= 1'b0;
    end
    else
    begin
      step_reg <= step_wide[NCO_W-1:0];
      nco_reg <= nco_reg + step_reg;
      // smoothed clock, or the raw aux clock when smoothing is bypassed
      if (output_clock_select == 2'b01 && !smooth_clock_out_select)
        smoothed_tx_clock_out <= aux_sync_reg[2];
      else
        smoothed_tx_clock_out <= nco_reg[NCO_W-1];
    end
  end

  assign nco_rise = nco_reg[NCO_W-1] && !smoothed_tx_clock_out;
  // elastic store: gapped aux clock reads the FIFO
  assign out_edge = (output_clock_select == 2'b01) ? aux_rise : nco_rise;

  // ----------------------------------------
  // fifo control
  // ----------------------------------------
  ja_fifo #(
    .WIDTH(1),
    .DEPTH(DEPTH),
    .AW(6)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .wr_data(bp_data_s3_reg),
    .wr_valid(bp_rise),
    .wr_ready(data_in_ready),
    .rd_data(fifo_rd_data),
    .rd_valid(fifo_rd_valid),
    .rd_ready(read_now),
    .skip(skip),
    .level(level)
  );

  assign near_over = level >= DEPTH - `JA_LIMIT_MARGIN;
  assign near_under = level <= `JA_LIMIT_MARGIN;

  // phase delay in UI tracked as output clock edges since last input comparator tick
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ui_delay_reg <= 7'h00;
    else if (in_tick_reg)
      ui_delay_reg <= 7'h00;
    else if (out_edge && ui_delay_reg != 7'h7F)
      ui_delay_reg <= ui_delay_reg + 7'h01;
  end

  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_FILL:
      begin
        if (self_center_enable_en && level >= `JA_CENTER_MARGIN)
          state_next = ST_CENTER;
        else if (!self_center_enable_en)
          state_next = ST_RUN;
      end
      ST_CENTER:
      begin
        if (level >= DEPTH / 2)
          state_next = ST_RUN;
      end
      ST_RUN:
      begin
        if (self_center_enable_en && !centered_reg)
          state_next = ST_FILL;
      end
      default:
        state_next = ST_FILL;
    endcase
  end

  // hold reads while centring; limit pauses read near underflow, skips near overflow
  assign read_now = out_edge && fifo_rd_valid && (state_reg == ST_RUN) &&
    !(limit_en && near_under && nudge_reg) &&
    !(sync_en && ({1'b0, level[5:0]} < ui_delay_reg));
  assign skip = limit_en && near_over && !nudge_reg && (state_reg == ST_RUN);

  // ----------------------------------------
  // state and output bit
  // ----------------------------------------

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= ST_FILL;
      centered_reg <= 1'b0;
      nudge_reg <= 1'b0;
      tx_data_out <= 1'b0;
      read_done_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg == ST_CENTER && state_next == ST_RUN)
        centered_reg <= 1'b1;
      else if (!self_center_enable_en)
        centered_reg <= 1'b0;
      // alternate nudges so data never lost on both ends at once
      if (out_edge)
        nudge_reg <= !nudge_reg;
      // fifo data register fills on the read edge, so take it one cycle later
      read_done_reg <= read_now;
      if (read_done_reg)
        tx_data_out <= fifo_rd_data;
    end
  end
endmodule

// ### bench/jitter_attenuator_monitor.sv
// Purpose: port checker of the jitter attenuator
// Assumes: zero wait apb, shadows follow register writes
// Notes: bound to the top module
`timescale 1ns/10ps
module ja_monitor (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire aux_tx_clock_in,
  input wire tx_data_out,
  input wire data_in_ready
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire [9:0] idx = paddr[11:2];
  wire acc = psel && penable;
  wire rd = acc && !pwrite;
  wire mapped = idx >= 10'h018 && idx <= 10'h01C;
  reg [2:0] ctrl_sh;
  reg [7:0] in_sh;
  reg [7:0] out_sh;
  reg [1:0] sel_sh;
  // shadows of the writable registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_sh <= 3'h1;
      in_sh <= 8'h2F;
      out_sh <= 8'h2F;
      sel_sh <= 2'h0;
    end
    else if (acc && pwrite && pready)
    begin
      if (idx == 10'h018) ctrl_sh <= pwdata[2:0];
      if (idx == 10'h019) in_sh <= pwdata[7:0];
      if (idx == 10'h01A) out_sh <= pwdata[7:0];
      if (idx == 10'h01C) sel_sh <= pwdata[1:0];
    end
  end
  property p_ready; acc |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_err; acc && !mapped |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("no slave error");
  property p_err_phase; pslverr |-> acc && !mapped; endproperty
  a_err_phase: assert property (p_err_phase) else $error("stray slave error");
  property p_rd_zero; rd && !mapped |-> prdata == 32'h0; endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("unmapped read data");
  property p_ctrl; rd && idx == 10'h018 |-> prdata == {29'h0, ctrl_sh}; endproperty
  a_ctrl: assert property (p_ctrl) else $error("control readback");
  property p_in_div; rd && idx == 10'h019 |-> prdata == {24'h0, in_sh}; endproperty
  a_in_div: assert property (p_in_div) else $error("input divisor");
  property p_out_div; rd && idx == 10'h01A |-> prdata == {24'h0, out_sh}; endproperty
  a_out_div: assert property (p_out_div) else $error("output divisor");
  property p_full; rd && idx == 10'h01B && prdata[9:3] >= 7'h30 |-> !data_in_ready; endproperty
  a_full: assert property (p_full) else $error("ready while full");
  property p_hold; (sel_sh == 2'h1 && !aux_tx_clock_in) [*8] |-> $stable(tx_data_out); endproperty
  a_hold: assert property (p_hold) else $error("output bit moved");
endmodule
bind jitter_attenuator ja_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .aux_tx_clock_in(aux_tx_clock_in),
  .tx_data_out(tx_data_out), .data_in_ready(data_in_ready));

// ### bench/ja_backplane_model.sv
// Purpose: backplane side sending bursts of bits
// Assumes: clock high and low four pclk cycles each
// Notes: clock rests low, data shows the inverse bit after a burst
`timescale 1ns/10ps
module ja_backplane_model (
  input wire pclk,
  input wire presetn,
  input wire start,
  input wire [63:0] pattern,
  input wire [6:0] nbits,
  output reg bp_clock,
  output reg bp_data,
  output wire busy
);
  reg [6:0] left;
  reg [63:0] sh;
  reg [1:0] ph;
  assign busy = left != 7'h00;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      left <= 7'h00;
      sh <= 64'h0;
      ph <= 2'h0;
      bp_clock <= 1'b0;
      bp_data <= 1'b0;
    end
    else if (start && !busy)
    begin
      left <= nbits;
      sh <= pattern;
      bp_data <= pattern[0];
    end
    else if (busy)
    begin
      ph <= ph + 2'h1;
      if (ph == 2'h3)
      begin
        bp_clock <= !bp_clock;
        if (bp_clock)
        begin
          sh <= sh >> 1;
          left <= left - 7'h01;
          bp_data <= (left == 7'h01) ? !sh[0] : sh[1];
        end
      end
    end
  end
endmodule

// ### bench/jitter_attenuator_tb.sv
// Purpose: self-checking bench of the jitter attenuator
// Assumes: 50 MHz pclk, zero wait apb
// Notes: apb results queued, bits compared while draining
`timescale 1ns/10ps
module jitter_attenuator_tb;
  localparam [31:0] M = 32'hFFFFFFFF;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg aux = 1'b0;
  reg start = 1'b0;
  reg [63:0] pattern = 64'h0;
  reg [6:0] nbits = 7'h00;
  reg bp_d = 1'b0;
  reg sm_d = 1'b0;
  reg [31:0] seed = 32'h000018D8;
  reg [64:0] e;
  reg [64:0] exp_q[$];
  reg bit_q[$];
  integer sm_rises = 0;
  integer num_errors = 0;
  integer check_count = 0;
  integer i;
  wire [31:0] prdata;
  wire pready, pslverr, bp_clock, bp_data, smooth, tx_data, in_ready, busy;
  always #10 pclk = ~pclk;
  jitter_attenuator uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .backplane_tx_clock(bp_clock), .backplane_tx_data(bp_data),
    .aux_tx_clock_in(aux), .smoothed_tx_clock_out(smooth), .tx_data_out(tx_data),
    .data_in_ready(in_ready));
  ja_backplane_model partner (.pclk(pclk), .presetn(presetn), .start(start),
    .pattern(pattern), .nbits(nbits), .bp_clock(bp_clock), .bp_data(bp_data), .busy(busy));
  function [31:0] xs(input [31:0] s);
    reg [31:0] x;
    begin
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction
  task chk(input [95:0] what, input [31:0] want, input [31:0] got);
  begin
    check_count = check_count + 1;
    if (got !== want)
    begin
      $display("wrong value %0s expected %h seen %h", what, want, got);
      num_errors = num_errors + 1;
    end
  end
  endtask
  task stop_test;
  begin
    if (num_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  // watcher: input bits, output clock, apb results
  always @(posedge pclk)
  begin
    bp_d <= bp_clock;
    sm_d <= smooth;
    if (smooth && !sm_d) sm_rises = sm_rises + 1;
    if (bp_clock && !bp_d) bit_q.push_back(bp_data);
    if (psel && penable && pready && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      chk("pslverr", {31'h0, e[64]}, {31'h0, pslverr});
      chk("prdata", e[31:0], prdata & e[63:32]);
    end
  end
  task apb(input w, input [7:0] idx, input [31:0] d, input [31:0] m, input [31:0] x, input err);
  begin
    exp_q.push_back({err, m, x});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask
  task send(input [6:0] n);
  begin
    seed = xs(seed);
    pattern <= {seed, xs(seed)};
    nbits <= n;
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    @(posedge pclk);
  end
  endtask
  task drain(input integer n, input cmp);
  begin
    repeat (n)
    begin
      aux <= 1'b1;
      repeat (6) @(posedge pclk);
      if (cmp) chk("tx bit", {31'h0, bit_q.pop_front()}, {31'h0, tx_data});
      aux <= 1'b0;
      repeat (6) @(posedge pclk);
    end
  end
  endtask
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    send(7'h40);
    repeat (600) @(posedge pclk);
    chk("smooth clk", 32'h1, {31'h0, sm_rises > 0});
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    bit_q.delete();
    apb(1'b0, 8'h18, 32'h0, M, 32'h1, 1'b0);
    apb(1'b0, 8'h19, 32'h0, M, 32'h2F, 1'b0);
    apb(1'b0, 8'h1A, 32'h0, M, 32'h2F, 1'b0);
    apb(1'b0, 8'h1C, 32'h0, M, 32'h0, 1'b0);
    apb(1'b1, 8'h20, seed, 32'h0, 32'h0, 1'b1);
    apb(1'b0, 8'h20, 32'h0, M, 32'h0, 1'b1);
    for (i = 0; i < 8; i = i + 1)
    begin
      seed = xs(seed);
      apb(1'b1, i[0] ? 8'h1A : 8'h19, seed, 32'h0, 32'h0, 1'b0);
      apb(1'b0, i[0] ? 8'h1A : 8'h19, 32'h0, M, {24'h0, seed[7:0]}, 1'b0);
      apb(1'b1, 8'h18, i, 32'h0, 32'h0, 1'b0);
      apb(1'b0, 8'h18, 32'h0, M, i, 1'b0);
    end
    apb(1'b1, 8'h18, 32'h0, 32'h0, 32'h0, 1'b0);
    apb(1'b1, 8'h1A, 32'hC0, 32'h0, 32'h0, 1'b0);
    apb(1'b1, 8'h19, 32'h17, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 8'h19, 32'h0, M, 32'h17, 1'b0);
    apb(1'b0, 8'h18, 32'h0, M, 32'h0, 1'b0);
    apb(1'b1, 8'h19, 32'hC0, 32'h0, 32'h0, 1'b0);
    apb(1'b1, 8'h1A, 32'hC0, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 8'h19, 32'h0, M, 32'hC0, 1'b0);
    apb(1'b1, 8'h18, 32'h2, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 8'h18, 32'h0, M, 32'h2, 1'b0);
    apb(1'b1, 8'h1C, 32'hD, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 8'h1C, 32'h0, M, 32'hD, 1'b0);
    send(7'h28);
    while (busy) @(posedge pclk);
    repeat (8) @(posedge pclk);
    drain(40, 1'b1);
    send(7'h40);
    while (in_ready === 1'b1) @(posedge pclk);
    while (busy) @(posedge pclk);
    chk("in ready", 32'h0, {31'h0, in_ready});
    apb(1'b0, 8'h1B, 32'h0, 32'h3F8, 32'h180, 1'b0);
    drain(48, 1'b0);
    repeat (8) @(posedge pclk);
    apb(1'b0, 8'h1B, 32'h0, 32'h3F8, 32'h0, 1'b0);
    chk("in ready", 32'h1, {31'h0, in_ready});
    stop_test;
  end
  initial
  begin
    #(20 * 20000);
    num_errors = num_errors + 1;
    stop_test;
  end
endmodule
